// >>> hw/gdsm_pkg.sv
package gdsm_pkg;
   // frame layout
   localparam int FRAME_BITS = 16;
   localparam int CMD_BITS = 5;
   localparam int DATA_BITS = 11;
   localparam int ADDR_BITS = 4;
   localparam int RW_POS = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 11;
   localparam int NUM_REGS = 16;
   localparam logic [4:0] FRAME_BITS_5 = 5'h10;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   // register roles inside the small map
   localparam logic [3:0] ADDR_FAULT = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h2;
   localparam int CLEAR_LATCHED_FAULTS_POS = 0;
   localparam int TSD_POS = 6;
   localparam int ANY_FAULT_POS = 10;
   localparam logic [10:0] REG_DEFAULT = 11'h000;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   // enable reset pulse window
   localparam int CLK_MHZ = 125;
   localparam int RST_PULSE_MAX_NS = 40000;
   localparam int RST_PULSE_CYC = (RST_PULSE_MAX_NS * CLK_MHZ) / 1000;
   // power states
   typedef enum logic [1:0] {
      GDSM_SLEEP = 2'b00,
      GDSM_RUN = 2'b01,
      GDSM_FAULT = 2'b10
   } gdsm_state_e;
endpackage

// >>> hw/gdsm_enable_filter.sv
`timescale 1ns/1ps
`default_nettype none
// watches the enable pin: a short low pulse is a fault clear, a long low is sleep
module gdsm_enable_filter #(
   parameter int PULSE_CYC = gdsm_pkg::RST_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic enable,
   output logic sleep_req,
   output logic clear_pulse
);
   logic [31:0] low_cnt_r; // cycles enable has been low
   logic enable_d_r; // previous enable level

   // count low time; saturate one above the window
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_r <= 32'h0000_0000;
         enable_d_r <= 1'b0;
      end else begin
         enable_d_r <= enable;
         if (enable) begin
            low_cnt_r <= 32'h0000_0000;
         end else if (low_cnt_r <= 32'(PULSE_CYC)) begin
            low_cnt_r <= low_cnt_r + 32'h0000_0001;
         end
      end
   end

   // past the window the low is a shutdown, not a reset pulse
   assign sleep_req = !enable && (low_cnt_r >= 32'(PULSE_CYC));
   // rising edge after a low within the window clears faults only
   assign clear_pulse = enable && !enable_d_r && (low_cnt_r != 32'h0000_0000)
      && (low_cnt_r < 32'(PULSE_CYC));
endmodule // gdsm_enable_filter
`default_nettype wire

// >>> hw/gdsm_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - enable low holds device asleep, all off
// - entering sleep restores every register default
// - enable high, supply good: operating mode
// - fault event while operating forces partial shutdown until cleared
// - clear by command bit or enable pulse
// - overlong enable low starts full sleep
// - enable pulse clears only latched faults
// - frame is 5 command plus 11 data
// - select high: ignore clock, release data-out
// - sample on falling, launch on rising
// - both frames shift msb first
// - only exactly 16 clocks make valid frame
// - write frame returns old register contents
// - data-out only pulls low, never high
// - rw flag, 4 address, 11 data bits
// - flag zero writes, flag one reads
// - five don't-care bits, then register data
// - latched faults stay until cleared
module gdsm_core #(
   parameter int PULSE_CYC = gdsm_pkg::RST_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic enable,
   input wire logic supply_undervoltage_lockout,
   input wire logic fault_event,
   input wire logic thermal_event,
   input wire logic fault_cond_active,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   output logic regulators_on,
   output logic gate_drive_on,
   output logic serial_port_on,
   output logic thermal_shutdown_flag,
   output logic [gdsm_pkg::DATA_BITS-1:0] control_word
);
   gdsm_pkg::gdsm_state_e state_r; // power state
   logic sleep_req; // long enable low
   logic clear_pulse; // short enable low then high
   logic [gdsm_pkg::DATA_BITS-1:0] regs_r [gdsm_pkg::NUM_REGS]; // register file
   logic latched_fault_r; // any latched fault
   logic thermal_shutdown_flag_r; // sticky thermal flag
   logic sclk_d_r; // previous serial clock
   logic csn_d_r; // previous chip select
   logic [4:0] bit_cnt_r; // falling edges seen in frame
   logic [gdsm_pkg::FRAME_BITS-1:0] shift_in_r; // received bits
   logic [gdsm_pkg::FRAME_BITS-1:0] shift_out_r; // bits to send
   logic sdo_bit_r; // launched output bit
   logic sclk_fall; // sample strobe
   logic sclk_rise; // launch strobe
   logic frame_end; // select rising
   logic frame_ok; // exactly 16 clocks seen
   logic frame_write; // committed write
   logic clear_latched_faults; // command bit write
   // a clear only counts once the fault condition has gone; otherwise the flags
   // would drop while the part is still held in partial shutdown
   logic clear_ok; // clear request with the condition removed
   logic port_live; // serial port enabled and selected
   logic [gdsm_pkg::ADDR_BITS-1:0] cur_addr; // address after 5 bits

   gdsm_enable_filter #(
      .PULSE_CYC(PULSE_CYC)
   ) u_enable_filter (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .enable(enable),
      .sleep_req(sleep_req),
      .clear_pulse(clear_pulse)
   );

   // serial port only alive in operating or fault state
   assign serial_port_on = (state_r != gdsm_pkg::GDSM_SLEEP);
   assign port_live = serial_port_on && !chip_select_n;
   assign sclk_fall = port_live && sclk_d_r && !sclk;
   assign sclk_rise = port_live && !sclk_d_r && sclk;
   assign frame_end = serial_port_on && !csn_d_r && chip_select_n;
   assign frame_ok = (bit_cnt_r == gdsm_pkg::FRAME_BITS_5);
   assign frame_write = frame_end && frame_ok
      && (shift_in_r[gdsm_pkg::RW_POS] == gdsm_pkg::RW_WRITE);
   assign clear_latched_faults = frame_write
      && (shift_in_r[gdsm_pkg::ADDR_HI:gdsm_pkg::ADDR_LO] == gdsm_pkg::ADDR_CTRL)
      && shift_in_r[gdsm_pkg::CLEAR_LATCHED_FAULTS_POS];
   assign cur_addr = shift_in_r[gdsm_pkg::ADDR_BITS-1:0];
   // either clear source, gated by the condition input
   assign clear_ok = (clear_pulse || clear_latched_faults) && !fault_cond_active;

   // power state machine
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= gdsm_pkg::GDSM_SLEEP;
      end else begin
         unique case (state_r)
            gdsm_pkg::GDSM_SLEEP: begin
               // wake only when supply is good
               if (enable && !supply_undervoltage_lockout) begin
                  state_r <= gdsm_pkg::GDSM_RUN;
               end
            end
            gdsm_pkg::GDSM_RUN: begin
               if (sleep_req || supply_undervoltage_lockout) begin
                  state_r <= gdsm_pkg::GDSM_SLEEP;
               end else if (fault_event || thermal_event) begin
                  state_r <= gdsm_pkg::GDSM_FAULT;
               end
            end
            gdsm_pkg::GDSM_FAULT: begin
               if (sleep_req || supply_undervoltage_lockout) begin
                  state_r <= gdsm_pkg::GDSM_SLEEP;
               end else if (!fault_cond_active && (clear_pulse || clear_latched_faults)) begin
                  state_r <= gdsm_pkg::GDSM_RUN;
               end
            end
            default: begin
               state_r <= gdsm_pkg::GDSM_SLEEP;
            end
         endcase
      end
   end

   // latched fault flags; a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         latched_fault_r <= 1'b0;
         thermal_shutdown_flag_r <= 1'b0;
      end else if (state_r == gdsm_pkg::GDSM_SLEEP) begin
         latched_fault_r <= 1'b0;
         thermal_shutdown_flag_r <= 1'b0;
      end else begin
         if (fault_event || thermal_event) begin
            latched_fault_r <= 1'b1;
         end else if (clear_ok) begin
            latched_fault_r <= 1'b0;
         end
         // thermal flag follows the same set-wins rule
         if (thermal_event) begin
            thermal_shutdown_flag_r <= 1'b1;
         end else if (clear_ok) begin
            thermal_shutdown_flag_r <= 1'b0;
         end
      end
   end

   // edge history of the serial pins
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_d_r <= 1'b0;
         csn_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk;
         csn_d_r <= chip_select_n;
      end
   end

   // receive shifter; counter saturates so 17+ clocks stay an error
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_cnt_r <= gdsm_pkg::CNT_ZERO;
         shift_in_r <= 16'h0000;
      end else if (!port_live) begin
         if (chip_select_n && csn_d_r) begin
            bit_cnt_r <= gdsm_pkg::CNT_ZERO;
         end
      end else if (sclk_fall) begin
         shift_in_r <= {shift_in_r[gdsm_pkg::FRAME_BITS-2:0], sdi};
         if (bit_cnt_r != 5'h1f) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // transmit shifter: loads old contents after the command bits
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_out_r <= 16'h0000;
         sdo_bit_r <= 1'b1;
      end else if (!port_live) begin
         sdo_bit_r <= 1'b1; // released
      end else begin
         if (sclk_fall && bit_cnt_r == 5'(gdsm_pkg::CMD_BITS - 1)) begin
            // fifth bit just arriving completes the address
            shift_out_r <= {regs_r[{cur_addr[gdsm_pkg::ADDR_BITS-2:0], sdi}],
               5'h00};
         end
         if (sclk_rise) begin
            sdo_bit_r <= (bit_cnt_r > 5'(gdsm_pkg::CMD_BITS - 1))
               ? shift_out_r[gdsm_pkg::FRAME_BITS-1] : 1'b1;
            if (bit_cnt_r > 5'(gdsm_pkg::CMD_BITS - 1)) begin
               shift_out_r <= {shift_out_r[gdsm_pkg::FRAME_BITS-2:0], 1'b0};
            end
         end
      end
   end

   // register file: write on select rise, defaults in sleep
   genvar gi;
   generate
      for (gi = 0; gi < gdsm_pkg::NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               regs_r[gi] <= gdsm_pkg::REG_DEFAULT;
            end else if (state_r == gdsm_pkg::GDSM_SLEEP) begin
               regs_r[gi] <= gdsm_pkg::REG_DEFAULT;
            end else if (gi == int'(gdsm_pkg::ADDR_FAULT)) begin
               // status is read-only: rebuilt every cycle, writes to it are lost
               regs_r[gi] <= status_word(latched_fault_r, thermal_shutdown_flag_r);
            end else if (frame_write
               && shift_in_r[gdsm_pkg::ADDR_HI:gdsm_pkg::ADDR_LO] == 4'(gi)) begin
               regs_r[gi] <= shift_in_r[gdsm_pkg::DATA_BITS-1:0];
               if (gi == int'(gdsm_pkg::ADDR_CTRL)) begin
                  regs_r[gi][gdsm_pkg::CLEAR_LATCHED_FAULTS_POS] <= 1'b0; // self-clearing
               end
            end
         end
      end
   endgenerate

   // status word built from the latched flags
   function automatic logic [gdsm_pkg::DATA_BITS-1:0] status_word(
      input logic any_f, input logic tsd_f);
      logic [gdsm_pkg::DATA_BITS-1:0] w;
      w = gdsm_pkg::REG_DEFAULT;
      w[gdsm_pkg::ANY_FAULT_POS] = any_f;
      w[gdsm_pkg::TSD_POS] = tsd_f;
      return w;
   endfunction

   // open-drain: enable only when pulling low
   assign sdo_o = 1'b0;
   assign sdo_oe = port_live && !sdo_bit_r;
   assign regulators_on = serial_port_on;
   assign gate_drive_on = (state_r == gdsm_pkg::GDSM_RUN);
   assign thermal_shutdown_flag = thermal_shutdown_flag_r;
   assign control_word = regs_r[gdsm_pkg::ADDR_CTRL];

   // assertions
   sleep_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == gdsm_pkg::GDSM_SLEEP) |-> !serial_port_on && !gate_drive_on)
      else $error("outputs active in sleep");
   sleep_default_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == gdsm_pkg::GDSM_SLEEP) |=> (control_word == gdsm_pkg::REG_DEFAULT))
      else $error("register kept in sleep");
   wake_run_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == gdsm_pkg::GDSM_SLEEP && enable && !supply_undervoltage_lockout)
      |=> (state_r == gdsm_pkg::GDSM_RUN))
      else $error("no wake");
   fault_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == gdsm_pkg::GDSM_RUN && fault_event && !sleep_req
      && !supply_undervoltage_lockout) |=> !gate_drive_on)
      else $error("fault did not stop drive");
   tsd_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (thermal_shutdown_flag && !clear_pulse && !clear_latched_faults
      && state_r != gdsm_pkg::GDSM_SLEEP) |=> thermal_shutdown_flag)
      else $error("thermal flag dropped");
   pulse_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      clear_pulse && !frame_write && state_r != gdsm_pkg::GDSM_SLEEP
      |=> $stable(control_word))
      else $error("pulse changed settings");
   odrain_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sdo_oe |-> !sdo_o)
      else $error("data-out driven high");
   idle_hiz_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      chip_select_n |-> !sdo_oe)
      else $error("data-out driven while deselected");
   bad_frame_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_end && !frame_ok && state_r != gdsm_pkg::GDSM_SLEEP |=> $stable(control_word))
      else $error("bad frame wrote register");

   // a clean clear request in fault state, with nothing pulling toward sleep
   sequence clean_clear_s;
      state_r == gdsm_pkg::GDSM_FAULT && !fault_cond_active
      && (clear_pulse || clear_latched_faults)
      && !sleep_req && !supply_undervoltage_lockout;
   endsequence

   // after a clean clear the drivers come back on the next cycle
   fault_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      clean_clear_s |=> (state_r == gdsm_pkg::GDSM_RUN))
      else $error("clear did not resume operation");

   // lockout drops any awake state straight to sleep
   supply_undervoltage_lockout_sleep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      supply_undervoltage_lockout && state_r != gdsm_pkg::GDSM_SLEEP
      |=> (state_r == gdsm_pkg::GDSM_SLEEP))
      else $error("lockout did not sleep");

   // a thermal event outside sleep always lands in the sticky flag
   tsd_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      thermal_event && state_r != gdsm_pkg::GDSM_SLEEP |=> thermal_shutdown_flag)
      else $error("thermal flag not set");

   // deselect with deselect history always clears the bit counter
   cnt_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      chip_select_n && csn_d_r |=> (bit_cnt_r == gdsm_pkg::CNT_ZERO))
      else $error("bit counter kept across frames");

   // data-out stays released during the command bit times
   cmd_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sclk_rise && bit_cnt_r <= 5'(gdsm_pkg::CMD_BITS - 1) |=> sdo_bit_r)
      else $error("data-out pulled during command bits");

   // after the command bits each rise launches the top of the shifter
   msb_launch_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sclk_rise && bit_cnt_r > 5'(gdsm_pkg::CMD_BITS - 1)
      |=> (sdo_bit_r == $past(shift_out_r[gdsm_pkg::FRAME_BITS-1])))
      else $error("wrong output bit launched");

   // a committed control write lands with the clear bit already dropped
   ctrl_commit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_write && shift_in_r[gdsm_pkg::ADDR_HI:gdsm_pkg::ADDR_LO] == gdsm_pkg::ADDR_CTRL
      |=> (control_word == {$past(shift_in_r[gdsm_pkg::DATA_BITS-1:1]), 1'b0}))
      else $error("control write not committed");
endmodule // gdsm_core
`default_nettype wire

// >>> bench/gdsm_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// master controller model: launches on the sclk rise, captures on the fall
module gdsm_spi_master (
   input wire logic sys_clk,
   input wire logic sdo_line,
   output logic chip_select_n,
   output logic sclk,
   output logic sdi
);
   localparam int HALF = 4; // sys_clk cycles per sclk level, twice the minimum
   localparam int GAP = 60; // deselect gap of 480 ns
   // idle: deselected, clock parked low
   initial begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b1;
   end
   // one frame of n clocks; counts other than 16 exercise frame errors
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge sys_clk) chip_select_n <= 1'b0; // clock low at select fall
      for (int i = 0; i < n; i++) begin
         repeat (HALF) @(posedge sys_clk);
         sclk <= 1'b1; // launch edge
         sdi <= tx[15 - (i % 16)]; // command then data, msb first
         repeat (HALF) @(posedge sys_clk);
         rx = {rx[14:0], sdo_line}; // capture edge
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      chip_select_n <= 1'b1; // clock low at select rise
      sdi <= ~sdi; // released line must not keep showing the last bit
      repeat (GAP) @(posedge sys_clk); // deselect gap
   endtask
   // clock and data activity while deselected; ends with the clock low
   task automatic noise();
      for (int i = 0; i < 8; i++) begin
         repeat (2) @(posedge sys_clk);
         sclk <= ~sclk;
         sdi <= ~sdi;
      end
   endtask
endmodule // gdsm_spi_master
`default_nettype wire

// >>> bench/gate_driver_spi_and_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module gate_driver_spi_and_mode_control_tb_top;
   localparam int PULSE = 50; // shortened enable window
   typedef struct packed {logic [3:0] addr; logic [10:0] data;} gdsm_row_s;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic enable = 1'b0;
   logic supply_undervoltage_lockout = 1'b0;
   logic fault_event = 1'b0;
   logic thermal_event = 1'b0;
   logic fault_cond_active = 1'b0;
   logic chip_select_n, sclk, sdi, sdo_o, sdo_oe;
   logic regulators_on, gate_drive_on, serial_port_on, thermal_shutdown_flag;
   logic [gdsm_pkg::DATA_BITS-1:0] control_word;
   logic [15:0] rx;
   wire logic sdo_line;
   int errors = 0;
   int total_checks = 0;
   // rows: listed address, value written and later read back
   gdsm_row_s rows [4] = '{'{4'h3, 11'h5a5}, '{4'h5, 11'h0f1}, '{4'h4, 11'h7fe},
                          '{gdsm_pkg::ADDR_CTRL, 11'h2a4}};
   // pull-up on the open-drain data-out line
   assign sdo_line = (sdo_oe === 1'b1) ? sdo_o : 1'b1;
   always #4 sys_clk = ~sys_clk;
   gdsm_core #(.PULSE_CYC(PULSE)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .enable(enable),
      .supply_undervoltage_lockout(supply_undervoltage_lockout), .fault_event(fault_event),
      .thermal_event(thermal_event), .fault_cond_active(fault_cond_active),
      .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .regulators_on(regulators_on), .gate_drive_on(gate_drive_on),
      .serial_port_on(serial_port_on), .thermal_shutdown_flag(thermal_shutdown_flag),
      .control_word(control_word));
   gdsm_spi_master master (.sys_clk(sys_clk), .sdo_line(sdo_line),
      .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // enable low for n+1 cycles, then high again
   task automatic en_low(input int n);
      @(posedge sys_clk) enable <= 1'b0;
      cyc(n);
      @(posedge sys_clk) enable <= 1'b1;
   endtask
   task automatic rd(input logic [3:0] a);
      master.xfer({gdsm_pkg::RW_READ, a, 11'h000}, 16, rx);
   endtask
   task automatic final_report();
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      cyc(3);
      @(posedge sys_clk) reset_n <= 1'b1;
      cyc(2);
      `CHK("regs_sleep", 1'b0, regulators_on)
      `CHK("port_sleep", 1'b0, serial_port_on)
      @(posedge sys_clk) enable <= 1'b1;
      cyc(10); // wake delay before any frame
      `CHK("gate_run", 1'b1, gate_drive_on)
      `CHK("port_run", 1'b1, serial_port_on)
      // ordinary cases: write returns old contents, read returns new
      foreach (rows[i]) begin
         master.xfer({gdsm_pkg::RW_WRITE, rows[i].addr, rows[i].data}, 16, rx);
         `CHK("old_val", 11'h000, rx[10:0])
         rd(rows[i].addr);
         `CHK("read_val", rows[i].data, rx[10:0])
      end
      `CHK("ctrl_word", 11'h2a4, control_word)
      // short and long frames are discarded
      master.xfer({gdsm_pkg::RW_WRITE, rows[0].addr, 11'h7ff}, 15, rx);
      master.xfer({gdsm_pkg::RW_WRITE, rows[0].addr, 11'h7ff}, 17, rx);
      master.xfer({gdsm_pkg::RW_WRITE, rows[0].addr, 11'h123}, 16, rx);
      `CHK("frame_err", rows[0].data, rx[10:0])
      // activity while deselected is ignored
      master.noise();
      `CHK("sdo_rel", 1'b0, sdo_oe)
      `CHK("sdo_low", 1'b0, sdo_o)
      rd(rows[0].addr);
      `CHK("after_noise", 11'h123, rx[10:0])
      // latched thermal fault with the condition still present
      @(posedge sys_clk) fault_cond_active <= 1'b1;
      thermal_event <= 1'b1;
      @(posedge sys_clk) thermal_event <= 1'b0;
      cyc(3);
      `CHK("gate_fault", 1'b0, gate_drive_on)
      `CHK("regs_fault", 1'b1, regulators_on)
      `CHK("tsd_set", 1'b1, thermal_shutdown_flag)
      rd(gdsm_pkg::ADDR_FAULT);
      `CHK("stat_any", 1'b1, rx[gdsm_pkg::ANY_FAULT_POS])
      `CHK("stat_tsd", 1'b1, rx[gdsm_pkg::TSD_POS])
      en_low(10);
      cyc(10);
      `CHK("gate_held", 1'b0, gate_drive_on)
      `CHK("tsd_held", 1'b1, thermal_shutdown_flag)
      // condition gone: a short enable pulse clears only the faults
      @(posedge sys_clk) fault_cond_active <= 1'b0;
      en_low(10);
      cyc(10);
      `CHK("gate_clr", 1'b1, gate_drive_on)
      `CHK("tsd_clr", 1'b0, thermal_shutdown_flag)
      `CHK("regs_kept", 1'b1, regulators_on)
      `CHK("ctrl_kept", 11'h2a4, control_word)
      rd(rows[1].addr);
      `CHK("reg_kept", rows[1].data, rx[10:0])
      // second fault cleared by the command bit
      @(posedge sys_clk) fault_event <= 1'b1;
      @(posedge sys_clk) fault_event <= 1'b0;
      cyc(3);
      `CHK("gate_f2", 1'b0, gate_drive_on)
      master.xfer({gdsm_pkg::RW_WRITE, gdsm_pkg::ADDR_CTRL, 11'h2a5}, 16, rx);
      `CHK("gate_cmd", 1'b1, gate_drive_on)
      // supply lockout stops operation
      @(posedge sys_clk) supply_undervoltage_lockout <= 1'b1;
      cyc(5);
      `CHK("gate_supply_undervoltage_lockout", 1'b0, gate_drive_on)
      @(posedge sys_clk) supply_undervoltage_lockout <= 1'b0;
      cyc(10);
      // fill registers again so the sleep default check has something to undo
      master.xfer({gdsm_pkg::RW_WRITE, rows[1].addr, rows[1].data}, 16, rx);
      master.xfer({gdsm_pkg::RW_WRITE, gdsm_pkg::ADDR_CTRL, 11'h2a4}, 16, rx);
      `CHK("ctrl_again", 11'h2a4, control_word)
      // overlong enable low means sleep, registers back to defaults
      @(posedge sys_clk) enable <= 1'b0;
      cyc(PULSE + 20);
      `CHK("regs_long", 1'b0, regulators_on)
      `CHK("gate_long", 1'b0, gate_drive_on)
      @(posedge sys_clk) enable <= 1'b1;
      cyc(10);
      rd(rows[1].addr);
      `CHK("reg_dflt", gdsm_pkg::REG_DEFAULT, rx[10:0])
      `CHK("ctrl_dflt", gdsm_pkg::REG_DEFAULT, control_word)
      final_report();
   end
   // watchdog: the sequence needs well under 10000 cycles
   initial begin
      cyc(20000);
      errors++;
      final_report();
   end
endmodule // gate_driver_spi_and_mode_control_tb_top
`default_nettype wire
